// [src/drive_serial_register_map.sv]
module drive_serial_register_map #(
   parameter int PARAM_DEPTH = drive_regmap_pkg::PARAM_DEPTH,
   parameter int PIDX_W      = 4
) (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   // Decoded request from the frame layer
   input  wire logic                  req_valid,
   input  wire logic                  req_write,
   input  wire logic                  req_broadcast,
   input  wire logic [15:0]           req_addr,
   input  wire logic [15:0]           req_wdata,
   // Answer to the frame layer
   output logic                       rsp_valid,
   output logic                       rsp_send,
   output logic [15:0]                rsp_rdata,
   output logic [7:0]                 rsp_error,
   // Staged parameter write port, active parameter read-back and commit status
   input  wire logic                  param_wr,
   input  wire logic [PIDX_W-1:0]     param_idx,
   input  wire logic [15:0]           param_wdata,
   input  wire logic [PIDX_W-1:0]     param_rd_idx,
   output logic [15:0]                param_active,
   output logic                       nv_write_pulse,
   output logic                       commit_busy,
   // Drive condition inputs
   input  wire logic [10:0]           status_low,
   input  wire logic                  overtorque,
   input  wire logic                  freq_ref_lost,
   input  wire logic                  retrying,
   input  wire logic                  drive_fault,
   input  wire logic                  relay_output_terminal,
   input  wire logic [1:0]            open_collector_output_terminal,
   input  wire logic [15:0]           dc_bus_voltage,
   input  wire logic [15:0]           pid_feedback,
   input  wire logic signed [15:0]    pid_input,
   input  wire logic signed [15:0]    pid_output,
   input  wire logic [15:0]           cpu_version,
   input  wire logic [15:0]           flash_version,
   input  wire logic [15:0]           power_rating,
   input  wire logic [15:0]           control_method,
   // Link error events
   input  wire logic                  ev_crc,
   input  wire logic                  ev_length,
   input  wire logic                  ev_parity,
   input  wire logic                  ev_overrun,
   input  wire logic                  ev_framing,
   input  wire logic                  ev_timeout,
   input  wire logic                  error_reset,
   // Local sequence signals
   input  wire logic                  local_run,
   input  wire logic                  local_reverse,
   input  wire logic                  local_ext_fault,
   input  wire logic                  local_fault_reset,
   input  wire logic [3:0]            local_multi_in,
   input  wire logic                  run_src_link,
   input  wire logic                  freq_src_link,
   input  wire logic [15:0]           local_freq_ref,
   // Effective commands to the drive
   output logic                       cmd_run,
   output logic                       cmd_reverse,
   output logic                       external_fault_input_setting,
   output logic                       fault_reset_input_setting,
   output logic [3:0]                 multi_input_five_to_eight,
   output logic [15:0]                freq_ref_scaled
);
   typedef struct packed {
      logic                           rsp_valid;
      logic                           rsp_send;
      logic [15:0]                    rsp_rdata;
      logic [7:0]                     rsp_error;
      logic [15:0]                    op_word;
      logic                           op_loaded;
      logic [15:0]                    freq_ref;
      logic                           freq_loaded;
      logic                           nv_pulse;
      logic [PIDX_W-1:0]              cidx;
      drive_regmap_pkg::commit_state_t cstate;
      logic                           c_nv;
   } map_state_t;

   map_state_t        state;
   map_state_t        next_state;
   logic [15:0]       staged [PARAM_DEPTH];
   logic [15:0]       active [PARAM_DEPTH];
   logic [6:0]        link_err;
   logic [6:0]        err_set;
   logic [15:0]       rd_word;
   logic              rd_ok;
   logic              is_commit;
   logic              op_reset_cmd;
   logic              clr_err;

   assign is_commit = (req_addr == drive_regmap_pkg::ADDR_COMMIT_NV)
                    || (req_addr == drive_regmap_pkg::ADDR_COMMIT_RAM);
   assign op_reset_cmd = state.op_loaded && state.op_word[drive_regmap_pkg::OP_FAULT_RST];
   assign clr_err = error_reset || op_reset_cmd;

   always_comb begin
      err_set = '0;
      err_set[drive_regmap_pkg::LE_CRC]     = ev_crc;
      err_set[drive_regmap_pkg::LE_LEN]     = ev_length;
      err_set[drive_regmap_pkg::LE_PARITY]  = ev_parity;
      err_set[drive_regmap_pkg::LE_OVERRUN] = ev_overrun;
      err_set[drive_regmap_pkg::LE_FRAMING] = ev_framing;
      err_set[drive_regmap_pkg::LE_TIMEOUT] = ev_timeout;
   end

   for (genvar g = 0; g < drive_regmap_pkg::LE_BITS; g++) begin : g_err
      if (drive_regmap_pkg::LE_USED_MASK[g]) begin : g_used
         sticky_bit u_bit (
            .mclk     (mclk),
            .sys_rst  (sys_rst),
            .set_in   (err_set[g]),
            .clear_in (clr_err),
            .flag     (link_err[g])
         );
      end else begin : g_unused
         assign link_err[g] = 1'b0;
      end
   end

   // Read multiplexer
   always_comb begin
      rd_word = '0;
      rd_ok   = 1'b1;
      case (req_addr)
         drive_regmap_pkg::ADDR_STATUS: begin
            rd_word[drive_regmap_pkg::ST_LOW_BITS-1:0] = status_low;
            rd_word[drive_regmap_pkg::ST_OVERTORQUE]   = overtorque;
            rd_word[drive_regmap_pkg::ST_FREQ_LOST]    = freq_ref_lost;
            rd_word[drive_regmap_pkg::ST_RETRY]        = retrying;
            rd_word[drive_regmap_pkg::ST_ANY_FAULT]    = drive_fault
                                                       || link_err[drive_regmap_pkg::LE_TIMEOUT];
            rd_word[drive_regmap_pkg::ST_TIMEOUT]      = link_err[drive_regmap_pkg::LE_TIMEOUT];
         end
         drive_regmap_pkg::ADDR_OUT_STAT: begin
            rd_word[drive_regmap_pkg::OUT_TERMS-1:0] = {open_collector_output_terminal,
                                                         relay_output_terminal};
         end
         drive_regmap_pkg::ADDR_DC_BUS:    rd_word = dc_bus_voltage;
         drive_regmap_pkg::ADDR_PID_FB:    rd_word = pid_feedback;
         drive_regmap_pkg::ADDR_PID_IN:    rd_word = pid_input;
         drive_regmap_pkg::ADDR_PID_OUT:   rd_word = pid_output;
         drive_regmap_pkg::ADDR_CPU_VER:   rd_word = cpu_version;
         drive_regmap_pkg::ADDR_FLASH_VER: rd_word = flash_version;
         drive_regmap_pkg::ADDR_LINK_ERR:  rd_word = {9'h000, link_err};
         drive_regmap_pkg::ADDR_KVA:       rd_word = power_rating;
         drive_regmap_pkg::ADDR_CTRL_METH: rd_word = control_method;
         default: begin
            rd_ok = (req_addr > drive_regmap_pkg::ADDR_OUT_STAT)
                 && (req_addr < drive_regmap_pkg::ADDR_PID_FB);
         end
      endcase
   end

   always_comb begin
      next_state = state;
      next_state.rsp_valid = 1'b0;
      next_state.nv_pulse  = 1'b0;
      // Fault reset acts once, a fresh write wins
      if (op_reset_cmd) begin
         next_state.op_word[drive_regmap_pkg::OP_FAULT_RST] = 1'b0;
      end
      if (req_valid) begin
         next_state.rsp_valid = 1'b1;
         next_state.rsp_send  = !req_broadcast;
         next_state.rsp_error = drive_regmap_pkg::ERR_NONE;
         next_state.rsp_rdata = '0;
         if (req_broadcast && (req_addr > drive_regmap_pkg::ADDR_BCAST_MAX)) begin
            next_state.rsp_error = drive_regmap_pkg::ERR_BAD_REG;
         end else if (!req_write) begin
            if (is_commit || !rd_ok || (req_addr == drive_regmap_pkg::ADDR_OP_WORD)
                || (req_addr == drive_regmap_pkg::ADDR_FREQ_REF)) begin
               next_state.rsp_error = drive_regmap_pkg::ERR_BAD_REG;
            end else begin
               next_state.rsp_rdata = rd_word;
            end
         end else if (req_addr == drive_regmap_pkg::ADDR_OP_WORD) begin
            next_state.op_word   = req_wdata;
            next_state.op_loaded = 1'b1;
         end else if (req_addr == drive_regmap_pkg::ADDR_FREQ_REF) begin
            next_state.freq_ref    = req_wdata;
            next_state.freq_loaded = 1'b1;
         end else if (is_commit) begin
            if (req_wdata != drive_regmap_pkg::COMMIT_VALUE) begin
               next_state.rsp_error = drive_regmap_pkg::ERR_BAD_DATA;
            end else if (state.cstate == drive_regmap_pkg::CM_IDLE) begin
               next_state.cstate = drive_regmap_pkg::CM_APPLY;
               next_state.cidx   = '0;
               next_state.c_nv   = (req_addr == drive_regmap_pkg::ADDR_COMMIT_NV);
            end
         end else begin
            next_state.rsp_error = drive_regmap_pkg::ERR_BAD_REG;
         end
      end
      case (state.cstate)
         drive_regmap_pkg::CM_IDLE: begin
         end
         drive_regmap_pkg::CM_APPLY: begin
            next_state.cidx = state.cidx + 1'b1;
            if (state.cidx == PIDX_W'(PARAM_DEPTH - 1)) begin
               next_state.cstate = state.c_nv ? drive_regmap_pkg::CM_NV
                                              : drive_regmap_pkg::CM_IDLE;
            end
         end
         drive_regmap_pkg::CM_NV: begin
            next_state.nv_pulse = 1'b1;
            next_state.cstate   = drive_regmap_pkg::CM_IDLE;
         end
         default: next_state.cstate = drive_regmap_pkg::CM_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state        <= '0;
         state.cstate <= drive_regmap_pkg::CM_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int i = 0; i < PARAM_DEPTH; i++) begin
            staged[i] <= '0;
            active[i] <= '0;
         end
      end else begin
         if (param_wr) begin
            staged[param_idx] <= param_wdata;
         end
         if (state.cstate == drive_regmap_pkg::CM_APPLY) begin
            active[state.cidx] <= staged[state.cidx];
         end
      end
   end

   assign param_active   = active[param_rd_idx];
   assign nv_write_pulse = state.nv_pulse;
   assign commit_busy    = (state.cstate != drive_regmap_pkg::CM_IDLE);
   assign rsp_valid      = state.rsp_valid;
   assign rsp_send       = state.rsp_send;
   assign rsp_rdata      = state.rsp_rdata;
   assign rsp_error      = state.rsp_error;

   assign cmd_run     = (run_src_link && state.op_loaded)
                      ? state.op_word[drive_regmap_pkg::OP_RUN] : local_run;
   assign cmd_reverse = (run_src_link && state.op_loaded)
                      ? state.op_word[drive_regmap_pkg::OP_REV] : local_reverse;
   assign external_fault_input_setting = local_ext_fault
                      || (state.op_loaded && state.op_word[drive_regmap_pkg::OP_EXT_FAULT]);
   assign fault_reset_input_setting = local_fault_reset || op_reset_cmd;
   assign multi_input_five_to_eight = state.op_loaded
                      ? state.op_word[drive_regmap_pkg::OP_MI_LO +: 4] : local_multi_in;
   assign freq_ref_scaled = (freq_src_link && state.freq_loaded)
                      ? ((state.freq_ref > drive_regmap_pkg::FREQ_FULL_SCALE)
                         ? drive_regmap_pkg::FREQ_FULL_SCALE : state.freq_ref)
                      : local_freq_ref;

   chk_commit_read: assert property (@(posedge mclk) disable iff (sys_rst)
      (req_valid && !req_write && is_commit && !req_broadcast)
      |=> (rsp_valid && rsp_error == drive_regmap_pkg::ERR_BAD_REG))
      else $error("commit read not rejected");
   chk_bcast_silent: assert property (@(posedge mclk) disable iff (sys_rst)
      (req_valid && req_broadcast) |=> (rsp_valid && !rsp_send))
      else $error("broadcast answered");
   chk_nv_after_apply: assert property (@(posedge mclk) disable iff (sys_rst)
      nv_write_pulse |-> $past(state.cstate) == drive_regmap_pkg::CM_NV)
      else $error("nv write without commit");
   chk_err_reg_read: assert property (@(posedge mclk) disable iff (sys_rst)
      (req_valid && !req_write && !req_broadcast && req_addr == drive_regmap_pkg::ADDR_LINK_ERR)
      |=> rsp_rdata == {9'h000, $past(link_err)})
      else $error("error detail read mismatch");
   chk_freq_clamp: assert property (@(posedge mclk) disable iff (sys_rst)
      (freq_src_link && state.freq_loaded)
      |-> freq_ref_scaled <= drive_regmap_pkg::FREQ_FULL_SCALE)
      else $error("frequency above full scale");
   chk_bcast_range: assert property (@(posedge mclk) disable iff (sys_rst)
      (req_valid && req_broadcast && req_addr > drive_regmap_pkg::ADDR_BCAST_MAX)
      |=> rsp_error == drive_regmap_pkg::ERR_BAD_REG)
      else $error("broadcast range not checked");
   chk_timeout_fault: assert property (@(posedge mclk) disable iff (sys_rst)
      (link_err[drive_regmap_pkg::LE_TIMEOUT] && req_valid && !req_write && !req_broadcast
       && req_addr == drive_regmap_pkg::ADDR_STATUS)
      |=> rsp_rdata[drive_regmap_pkg::ST_ANY_FAULT])
      else $error("timeout not in fault bit");
   chk_unused_zero: assert property (@(posedge mclk) disable iff (sys_rst)
      (req_valid && !req_write && !req_broadcast && req_addr == 16'h0030)
      |=> rsp_rdata == 16'h0000) else $error("unused register not zero");
   cov_commit_nv: cover property (@(posedge mclk) nv_write_pulse);
   cov_bcast_op: cover property (@(posedge mclk)
      req_valid && req_broadcast && req_write && req_addr == drive_regmap_pkg::ADDR_OP_WORD);
   cov_err_reset: cover property (@(posedge mclk) clr_err && link_err != 7'h00);
endmodule : drive_serial_register_map

// [src/drive_regmap_pkg.sv]
// Operation
// - Status bits B-F report drive conditions
// - Output status bits 0-2 mirror terminals
// - Link error detail bits at fixed positions
// - Error details latch until error reset
// - PID monitors scaled ten counts per percent
// - Read-only monitors; unused ranges read zero
// - Broadcast operation word bit decode
// - Frequency reference 30000 equals full scale
// - Broadcast registers are write-only
// - Undefined operation bits keep local values
// - Link parameter writes go to staging
// - Commit to RAM plus NV, or RAM only
// - Commit triggered by writing value zero
// - Commit register reads answer error 02H
// - Broadcast start beyond frequency register rejected
// - Slave address zero executes, sends no reply
package drive_regmap_pkg;
   localparam logic [15:0] ADDR_OP_WORD   = 16'h0001;
   localparam logic [15:0] ADDR_FREQ_REF  = 16'h0002;
   localparam logic [15:0] ADDR_STATUS    = 16'h002C;
   localparam logic [15:0] ADDR_OUT_STAT  = 16'h002D;
   localparam logic [15:0] ADDR_DC_BUS    = 16'h0031;
   localparam logic [15:0] ADDR_PID_FB    = 16'h0038;
   localparam logic [15:0] ADDR_PID_IN    = 16'h0039;
   localparam logic [15:0] ADDR_PID_OUT   = 16'h003A;
   localparam logic [15:0] ADDR_CPU_VER   = 16'h003B;
   localparam logic [15:0] ADDR_FLASH_VER = 16'h003C;
   localparam logic [15:0] ADDR_LINK_ERR  = 16'h003D;
   localparam logic [15:0] ADDR_KVA       = 16'h003E;
   localparam logic [15:0] ADDR_CTRL_METH = 16'h003F;
   localparam logic [15:0] ADDR_COMMIT_NV = 16'h0900;
   localparam logic [15:0] ADDR_COMMIT_RAM = 16'h0910;
   localparam logic [15:0] ADDR_BCAST_MAX = 16'h0002;
   localparam logic [15:0] COMMIT_VALUE   = 16'h0000;
   localparam logic [15:0] FREQ_FULL_SCALE = 16'h7530;
   localparam logic [7:0]  ERR_NONE       = 8'h00;
   localparam logic [7:0]  ERR_BAD_REG    = 8'h02;
   localparam logic [7:0]  ERR_BAD_DATA   = 8'h21;
   localparam int          OP_RUN         = 0;
   localparam int          OP_REV         = 1;
   localparam int          OP_EXT_FAULT   = 4;
   localparam int          OP_FAULT_RST   = 5;
   localparam int          OP_MI_LO       = 12;
   localparam int          LE_CRC         = 0;
   localparam int          LE_LEN         = 1;
   localparam int          LE_PARITY      = 3;
   localparam int          LE_OVERRUN     = 4;
   localparam int          LE_FRAMING     = 5;
   localparam int          LE_TIMEOUT     = 6;
   localparam int          LE_BITS        = 7;
   localparam logic [6:0]  LE_USED_MASK   = 7'h7B;
   localparam int          ST_OVERTORQUE  = 11;
   localparam int          ST_FREQ_LOST   = 12;
   localparam int          ST_RETRY       = 13;
   localparam int          ST_ANY_FAULT   = 14;
   localparam int          ST_TIMEOUT     = 15;
   localparam int          ST_LOW_BITS    = 11;
   localparam int          OUT_TERMS      = 3;
   localparam int          PARAM_DEPTH    = 16;
   typedef enum logic [2:0] {
      CM_IDLE  = 3'b001,
      CM_APPLY = 3'b010,
      CM_NV    = 3'b100
   } commit_state_t;
endpackage : drive_regmap_pkg

// [src/sticky_bit.sv]
module sticky_bit (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // Event and clear
   input  wire logic set_in,
   input  wire logic clear_in,
   // Held flag
   output logic      flag
);
   typedef struct packed {
      logic flag;
   } sticky_state_t;

   sticky_state_t state;
   sticky_state_t next_state;

   always_comb begin
      next_state = state;
      if (set_in) begin
         next_state.flag = 1'b1;
      end else if (clear_in) begin
         next_state.flag = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign flag = state.flag;

   chk_set_holds: assert property (@(posedge mclk) disable iff (sys_rst)
      set_in |=> flag) else $error("sticky flag lost its set");
   chk_hold_no_clear: assert property (@(posedge mclk) disable iff (sys_rst)
      (flag && !clear_in) |=> flag) else $error("sticky flag dropped without clear");
endmodule : sticky_bit

// [verif/plc_master_model.sv]
module plc_master_model (
   // Clock
   input  wire logic        mclk,
   // Request to the register map
   output logic             req_valid,
   output logic             req_write,
   output logic             req_broadcast,
   output logic [15:0]      req_addr,
   output logic [15:0]      req_wdata,
   // Answer from the register map
   input  wire logic        rsp_valid,
   input  wire logic        rsp_send,
   input  wire logic [15:0] rsp_rdata,
   input  wire logic [7:0]  rsp_error
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      req_valid     = 1'b0;
      req_write     = 1'b0;
      req_broadcast = 1'b0;
      req_addr      = 16'h0000;
      req_wdata     = 16'h0000;
   end

   // Broadcast only written, commit data zero except one 0005H rejection write, NV commit used sparingly
   task automatic xfer(input logic w, input logic b, input logic [15:0] a,
                       input logic [15:0] d, output logic [15:0] rd,
                       output logic [7:0] er, output logic snd, output logic vld);
      @(posedge mclk);
      #1;
      req_valid     = 1'b1;
      req_write     = w;
      req_broadcast = b;
      req_addr      = a;
      req_wdata     = d;
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      req_addr  = ~a;
      req_wdata = ~d;
      rd        = rsp_rdata;
      er        = rsp_error;
      snd       = rsp_send;
      vld       = rsp_valid;
   endtask : xfer
endmodule : plc_master_model

// [verif/tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk, sys_rst, req_valid, req_write, req_broadcast, rsp_valid, rsp_send;
   logic [15:0] req_addr, req_wdata, rsp_rdata, param_wdata, param_active, rdv;
   logic [7:0]  rsp_error, erv;
   logic param_wr, nv_write_pulse, commit_busy, snd, vld;
   logic [3:0]  param_idx, param_rd_idx, local_multi_in, mi_out;
   logic [10:0] status_low;
   logic ovt, flost, retry, dfault, relay, run_src, freq_src, l_run, l_rev, l_ext, l_frst;
   logic [1:0]  oc;
   logic [15:0] dcv, pfb, pin, pout, cpuv, flv, pwr, cmeth, lfreq, freq_out;
   logic ev_crc, ev_len, ev_par, ev_ovr, ev_frm, ev_to, err_rst;
   logic cmd_run, cmd_rev, ext_out, frst_out;
   int err_count, tests_run, nv_seen;

   plc_master_model plc (.mclk(mclk), .req_valid(req_valid), .req_write(req_write),
      .req_broadcast(req_broadcast), .req_addr(req_addr), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_send(rsp_send), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error));

   drive_serial_register_map uut (.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid),
      .req_write(req_write), .req_broadcast(req_broadcast), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_send(rsp_send),
      .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .param_wr(param_wr),
      .param_idx(param_idx), .param_wdata(param_wdata), .param_rd_idx(param_rd_idx),
      .param_active(param_active), .nv_write_pulse(nv_write_pulse),
      .commit_busy(commit_busy), .status_low(status_low), .overtorque(ovt),
      .freq_ref_lost(flost), .retrying(retry), .drive_fault(dfault),
      .relay_output_terminal(relay), .open_collector_output_terminal(oc),
      .dc_bus_voltage(dcv), .pid_feedback(pfb), .pid_input(pin), .pid_output(pout),
      .cpu_version(cpuv), .flash_version(flv), .power_rating(pwr),
      .control_method(cmeth), .ev_crc(ev_crc), .ev_length(ev_len), .ev_parity(ev_par),
      .ev_overrun(ev_ovr), .ev_framing(ev_frm), .ev_timeout(ev_to), .error_reset(err_rst),
      .local_run(l_run), .local_reverse(l_rev), .local_ext_fault(l_ext),
      .local_fault_reset(l_frst), .local_multi_in(local_multi_in), .run_src_link(run_src),
      .freq_src_link(freq_src), .local_freq_ref(lfreq), .cmd_run(cmd_run),
      .cmd_reverse(cmd_rev), .external_fault_input_setting(ext_out),
      .fault_reset_input_setting(frst_out), .multi_input_five_to_eight(mi_out),
      .freq_ref_scaled(freq_out));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   always @(posedge mclk) if (nv_write_pulse === 1'b1) nv_seen++;

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic [7:0] eexp);
      plc.xfer(1'b0, 1'b0, a, 16'h0000, rdv, erv, snd, vld);
      check($sformatf("read %h", a), rdv, exp);
      check($sformatf("error %h", a), {8'h00, erv}, {8'h00, eexp});
      check("answer pulse", {15'h0000, vld}, 16'h0001);
   endtask : rd

   task automatic wr(input logic b, input logic [15:0] a, input logic [15:0] d,
                     input logic [7:0] eexp);
      plc.xfer(1'b1, b, a, d, rdv, erv, snd, vld);
      check($sformatf("write error %h", a), {8'h00, erv}, {8'h00, eexp});
      check("reply sent", {15'h0000, snd}, {15'h0000, ~b});
      check("write answer pulse", {15'h0000, vld}, 16'h0001);
   endtask : wr

   task automatic pulse_ev(input int k);
      @(posedge mclk);
      #1;
      {ev_to, ev_par, ev_crc, err_rst} = 4'h1 << k;
      @(posedge mclk);
      #1;
      {ev_to, ev_par, ev_crc, err_rst} = 4'h0;
   endtask : pulse_ev

   task automatic commit(input logic [15:0] a);
      int n;
      wr(1'b0, a, 16'h0000, 8'h00);
      check("commit busy", {15'h0000, commit_busy}, 16'h0001);
      for (n = 0; n < 40 && commit_busy !== 1'b0; n++) @(posedge mclk);
      repeat (2) @(posedge mclk);
      #1;
      check("commit finished", {15'h0000, commit_busy}, 16'h0000);
   endtask : commit

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict

   initial begin
      #300000;
      err_count++;
      print_verdict();
   end

   initial begin
      err_count = 0; tests_run = 0; nv_seen = 0; sys_rst = 1'b1;
      {param_wr, param_idx, param_wdata, param_rd_idx} = '0;
      status_low = 11'h155; {ovt, flost, retry, dfault} = 4'b1011; relay = 1'b1; oc = 2'b10;
      dcv = 16'h0123; pfb = 16'h03E8; pin = 16'hFC18; pout = 16'h8001; cpuv = 16'h0A11;
      flv = 16'h0B22; pwr = 16'h0C33; cmeth = 16'h0002; lfreq = 16'h1000;
      {ev_crc, ev_len, ev_par, ev_ovr, ev_frm, ev_to, err_rst} = '0;
      {l_run, l_rev, l_ext, l_frst, run_src, freq_src} = '0; local_multi_in = 4'h5;
      repeat (16) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      rd(16'h002C, 16'h6955, 8'h00);
      rd(16'h002D, 16'h0005, 8'h00);
      rd(16'h0031, dcv, 8'h00);
      rd(16'h0038, pfb, 8'h00);
      rd(16'h0039, pin, 8'h00);
      rd(16'h003A, pout, 8'h00);
      rd(16'h003B, cpuv, 8'h00);
      rd(16'h003C, flv, 8'h00);
      rd(16'h003E, pwr, 8'h00);
      rd(16'h003F, cmeth, 8'h00);
      rd(16'h002E, 16'h0000, 8'h00);
      rd(16'h0037, 16'h0000, 8'h00);
      rd(16'h0040, 16'h0000, 8'h02);
      $display("monitor test done");
      pulse_ev(1); pulse_ev(2); pulse_ev(3);
      rd(16'h003D, 16'h0049, 8'h00);
      rd(16'h002C, 16'hE955, 8'h00);
      repeat (5) @(posedge mclk);
      rd(16'h003D, 16'h0049, 8'h00);
      pulse_ev(0);
      rd(16'h003D, 16'h0000, 8'h00);
      pulse_ev(2);
      wr(1'b1, 16'h0001, 16'h0020, 8'h00);
      check("fault reset out", {15'h0000, frst_out}, 16'h0001);
      rd(16'h003D, 16'h0000, 8'h00);
      check("fault reset once", {15'h0000, frst_out}, 16'h0000);
      $display("link error test done");
      rd(16'h0001, 16'h0000, 8'h02);
      rd(16'h0002, 16'h0000, 8'h02);
      rd(16'h0900, 16'h0000, 8'h02);
      rd(16'h0910, 16'h0000, 8'h02);
      wr(1'b1, 16'h0003, 16'h0001, 8'h02);
      wr(1'b1, 16'h0001, 16'hA013, 8'h00);
      check("run local", {15'h0000, cmd_run}, 16'h0000);
      check("multi inputs", {12'h000, mi_out}, 16'h000A);
      check("ext fault", {15'h0000, ext_out}, 16'h0001);
      run_src = 1'b1;
      #1;
      check("run link", {14'h0000, cmd_run, cmd_rev}, 16'h0003);
      freq_src = 1'b1;
      wr(1'b1, 16'h0002, 16'd15000, 8'h00);
      check("freq mid", freq_out, 16'd15000);
      wr(1'b1, 16'h0002, 16'd40000, 8'h00);
      check("freq clamp", freq_out, drive_regmap_pkg::FREQ_FULL_SCALE);
      $display("broadcast test done");
      @(posedge mclk);
      #1;
      {param_wr, param_idx, param_wdata, param_rd_idx} = {1'b1, 4'h3, 16'h1234, 4'h3};
      @(posedge mclk);
      #1;
      param_wr = 1'b0;
      check("staged only", param_active, 16'h0000);
      wr(1'b0, 16'h0910, 16'h0005, 8'h21);
      check("nonzero commit", param_active, 16'h0000);
      commit(drive_regmap_pkg::ADDR_COMMIT_RAM);
      check("ram commit", param_active, 16'h1234);
      check("no nv write", 16'(nv_seen), 16'h0000);
      commit(drive_regmap_pkg::ADDR_COMMIT_NV);
      check("nv write", 16'(nv_seen), 16'h0001);
      $display("commit test done");
      print_verdict();
   end
endmodule : tb
